/* File: verilog/relay_cmd_regs.svh */
`ifndef RELAY_CMD_REGS_SVH
`define RELAY_CMD_REGS_SVH
// Register indices on the plain port (word addresses)
`define REG_CMD        4'h0
`define REG_ARG        4'h1
`define REG_STATUS     4'h2
`define REG_GROUP      4'h3
`define REG_CLOSE_FAIL 4'h4
`define REG_TRIP_DUR   4'h5
`define REG_AUTO       4'h6
`define REG_TRIPCNT    4'h7
`define REG_EXTCNT     4'h8
`define REG_EVENT      4'h9
`define REG_TARGET     4'ha
`define REG_STAMP      4'hb
`define REG_YEAR       4'hc
`define REG_INASSIGN   4'hd
`define REG_SETPTR     4'he
// Reset values and limits
`define CLOSE_FAIL_RESET 14'h003c
`define TRIP_DUR_RESET   6'h04
`define AUTO_RESET     2'h3
`define CLOSE_FAIL_MAX   14'h3e80
`define TRIP_DUR_MAX     6'h3f
`define EVENT_MAX      4'hc
`define TARGET_MAX     4'h8
`define GROUP_MAX      3'h6
// Timing
`define CLK_HZ         50000000
`define ALARM_PULSE_MS 1000
`define POWER_CYC_HZ   60
`endif

/* File: verilog/relay_cmd_pkg.sv */
package relay_cmd_pkg;
	typedef enum logic [4:0] {
		CMD_NONE    = 5'h00,
		CMD_LOGIN1  = 5'h01,
		CMD_LOGIN2  = 5'h02,
		CMD_BRK_RST = 5'h03,
		CMD_DATE    = 5'h04,
		CMD_EVENT   = 5'h05,
		CMD_TARGET  = 5'h06,
		CMD_TAR_RST = 5'h07,
		CMD_TRIGGER = 5'h08,
		CMD_QUIT    = 5'h09,
		CMD_CLOSE   = 5'h0a,
		CMD_OPEN    = 5'h0b,
		CMD_COPY    = 5'h0c,
		CMD_GROUP   = 5'h0d,
		CMD_SET_GRP = 5'h0e,
		CMD_SET_GLB = 5'h0f,
		CMD_STORE_G = 5'h10
	} cmd_e;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_EXEC  = 3'b010,
		ST_GLOBS = 3'b100
	} state_e;
	typedef struct packed {
		logic [1:0] level;
		logic [1:0] fails;
		logic       reject;
	} session_s;
	typedef struct packed {
		state_e      st;
		session_s    ses;
		logic [4:0]  cmd;
		logic [15:0] arg;
		logic [2:0]  group;
		logic [13:0] close_fail;
		logic [5:0]  trip_dur;
		logic [1:0]  auto_sel;
		logic [15:0] trip_cnt;
		logic [15:0] xtrig_cnt;
		logic [31:0] isum;
		logic [31:0] stamp;
		logic [11:0] year;
		logic [3:0]  event_idx;
		logic [3:0]  target_sel;
		logic [3:0]  set_ptr;
		logic        dem_on_grp;
		logic [2:0]  in_assign;
		logic [25:0] alarm_cnt;
		logic        alarm;
		logic        clr_events;
		logic        dem_reset;
		logic        trigger;
		logic        close_out;
		logic        open_out;
		logic [13:0] close_cnt;
		logic [5:0]  trip_cnt_hold;
		logic        trip_out;
		logic [2:0]  msg_ports;
		logic [1:0]  sel_s1;
		logic [1:0]  sel_s2;
		logic [1:0]  brk_s1;
		logic [1:0]  brk_s2;
		logic [1:0]  tmo_s1;
		logic [1:0]  tmo_s2;
		logic        time_ovr;
		logic [31:0] rdata;
	} state_s;
endpackage

/* File: verilog/relay_cmd.sv */
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "relay_cmd_regs.svh"
module relay_cmd #(
	parameter int ALARM_CYCLES = (`CLK_HZ / 1000) * `ALARM_PULSE_MS,
	parameter int PCYC_CLKS    = `CLK_HZ / `POWER_CYC_HZ
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic [31:0]      rdata,
	input  wire logic        login_ok,
	input  wire logic        group_sel_one,
	input  wire logic        group_sel_two,
	input  wire logic        breaker_status_input,
	input  wire logic        breaker_jumper,
	input  wire logic        trip_request,
	input  wire logic [1:0]  port_timed_out,
	input  wire logic        time_code_valid,
	input  wire logic [31:0] time_now,
	input  wire logic        auto_msg_req,
	output logic             alarm_out,
	output logic             clear_events,
	output logic             demand_reset,
	output logic             event_trigger,
	output logic             close_out,
	output logic             open_out,
	output logic             trip_out,
	output logic [1:0]       auto_msg_port,
	output logic             external_event_type,
	output logic             time_override
);
	relay_cmd_pkg::state_s s_q, s_d;
	logic [25:0] alarm_len;
	logic [19:0] pcyc_len;
	logic [19:0] pcyc_q;
	logic        pcyc_tick;
	assign alarm_len = 26'(ALARM_CYCLES);
	assign pcyc_len  = 20'(PCYC_CLKS);

	// Required level per command; decoded only in command execution
	function automatic logic [1:0] need_level(input logic [4:0] c);
		case (c)
			5'h01:   need_level = 2'h0;
			5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09: need_level = 2'h1;
			default: need_level = 2'h2;
		endcase
	endfunction

	// Power-system cycle tick for the cycle-based timers
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pcyc_q <= 20'h00000;
		end else begin
			pcyc_q <= pcyc_tick ? 20'h00000 : pcyc_q + 20'h00001;
		end
	end
	assign pcyc_tick = (pcyc_q >= pcyc_len - 20'h00001);

	// All control state except the power-cycle tick counter computed here
	always_comb begin
		logic       sel_busy;
		logic [2:0] g;
		logic       pulse;
		sel_busy = 1'b0;
		g        = 3'h0;
		pulse    = 1'b0;
		s_d = s_q;
		s_d.clr_events = 1'b0;
		s_d.dem_reset  = 1'b0;
		s_d.trigger    = 1'b0;
		s_d.ses.reject = 1'b0;
		s_d.time_ovr   = time_code_valid;
		// Pin synchronisers, second stage only is read
		s_d.sel_s1 = {group_sel_two, group_sel_one};
		s_d.sel_s2 = s_q.sel_s1;
		s_d.brk_s1 = {trip_request, breaker_status_input};
		s_d.brk_s2 = s_q.brk_s1;
		s_d.tmo_s1 = port_timed_out;
		s_d.tmo_s2 = s_q.tmo_s1;
		// Group-select inputs only count where assigned; input two alone may carry select two
		sel_busy = (s_q.in_assign[0] & s_q.sel_s2[0]) | (s_q.in_assign[1] & s_q.sel_s2[1]);
		// Register writes
		if (wr_en) begin
			unique case (addr)
				`REG_CMD: begin
					s_d.cmd = wdata[4:0];
					s_d.st  = relay_cmd_pkg::ST_EXEC;
				end
				`REG_ARG: s_d.arg = wdata[15:0];
				`REG_CLOSE_FAIL: if (s_q.ses.level == 2'h2 && wdata[13:0] <= `CLOSE_FAIL_MAX)
					s_d.close_fail = wdata[13:0];
				`REG_TRIP_DUR: if (s_q.ses.level == 2'h2) s_d.trip_dur = wdata[5:0];
				`REG_AUTO: if (s_q.ses.level == 2'h2 && wdata[1:0] != 2'h0) s_d.auto_sel = wdata[1:0];
				`REG_INASSIGN: if (s_q.ses.level == 2'h2) begin
					s_d.in_assign  = {wdata[2], wdata[1], wdata[0]};
					s_d.dem_on_grp = wdata[4];
				end
				default: ;
			endcase
		end
		// Command execution
		if (s_q.st == relay_cmd_pkg::ST_EXEC) begin
			s_d.st = relay_cmd_pkg::ST_IDLE;
			if (need_level(s_q.cmd) > s_q.ses.level && s_q.cmd != 5'h02) begin
				s_d.ses.reject = 1'b1;
			end else begin
				unique case (s_q.cmd)
					5'h01: if (login_ok) begin
						s_d.ses.level = 2'h1;
						s_d.ses.fails = 2'h0;
					end else if (s_q.ses.fails == 2'h2) begin
						s_d.ses.fails = 2'h0;
						pulse = 1'b1;
					end else begin
						s_d.ses.fails = s_q.ses.fails + 2'h1;
					end
					5'h02: begin
						if (s_q.ses.level == 2'h0) s_d.ses.reject = 1'b1;
						else begin
							pulse = 1'b1;
							if (login_ok) s_d.ses.level = 2'h2;
						end
					end
					5'h03: begin
						s_d.trip_cnt = 16'h0000;
						s_d.xtrig_cnt = 16'h0000;
						s_d.isum     = 32'h00000000;
						s_d.stamp    = time_now;
					end
					5'h04: begin
						if (s_q.arg[11:0] != s_q.year) pulse = 1'b1;
						s_d.year = s_q.arg[11:0];
					end
					5'h05: if (s_q.arg[3:0] <= `EVENT_MAX)
						s_d.event_idx = (s_q.arg[3:0] == 4'h0) ? 4'h1 : s_q.arg[3:0];
					5'h06: if (s_q.arg[3:0] <= `TARGET_MAX) s_d.target_sel = s_q.arg[3:0];
					5'h07: s_d.target_sel = 4'h0;
					5'h08: begin
						s_d.trigger = 1'b1;
						s_d.xtrig_cnt = s_q.xtrig_cnt + 16'h0001;
					end
					5'h09: begin
						s_d.ses.level  = 2'h0;
						s_d.target_sel = 4'h0;
					end
					5'h0a: if (breaker_jumper && !s_q.open_out) begin
						s_d.close_out = 1'b1;
						s_d.close_cnt = s_q.close_fail;
					end else s_d.ses.reject = 1'b1;
					5'h0b: if (breaker_jumper) s_d.open_out = 1'b1;
					else s_d.ses.reject = 1'b1;
					5'h0c: begin
						g = s_q.arg[6:4];
						if (s_q.arg[2:0] >= 3'h1 && s_q.arg[2:0] <= `GROUP_MAX && g >= 3'h1 && g <= `GROUP_MAX) begin
							s_d.clr_events = 1'b1;
							if (g == s_q.group) pulse = 1'b1;
						end else s_d.ses.reject = 1'b1;
					end
					5'h0d: begin
						g = s_q.arg[2:0];
						if (!sel_busy && g >= 3'h1 && g <= `GROUP_MAX) begin
							if (g != s_q.group) begin
								s_d.group = g;
								pulse = 1'b1;
								s_d.dem_reset = s_q.dem_on_grp;
							end
						end else s_d.ses.reject = 1'b1;
					end
					5'h0e: begin
						s_d.clr_events = 1'b1;
						if (s_q.arg[2:0] == s_q.group) pulse = 1'b1;
					end
					5'h0f: begin
						s_d.set_ptr = s_q.arg[3:0];
						s_d.st = relay_cmd_pkg::ST_GLOBS;
					end
					default: s_d.ses.reject = 1'b1;
				endcase
			end
		end else if (s_q.st == relay_cmd_pkg::ST_GLOBS) begin
			// Waits for the confirm command; any other command abandons the edit
			if (wr_en && addr == `REG_CMD) begin
				if (wdata[4:0] == 5'h10) begin
					s_d.st = relay_cmd_pkg::ST_IDLE;
					pulse = 1'b1;
					s_d.clr_events = 1'b1;
				end
			end else if (wr_en && addr == `REG_ARG) begin
				s_d.st = relay_cmd_pkg::ST_GLOBS;
			end
		end
		// Alarm contact pulse; a new pulse restarts the full second
		if (pulse) begin
			s_d.alarm_cnt = alarm_len;
			s_d.alarm     = 1'b1;
		end else if (s_q.alarm_cnt != 26'h0000000) begin
			s_d.alarm_cnt = s_q.alarm_cnt - 26'h0000001;
			s_d.alarm     = (s_q.alarm_cnt != 26'h0000001);
		end
		// Trip hold in power cycles
		if (s_q.brk_s2[1]) begin
			s_d.trip_out      = 1'b1;
			s_d.trip_cnt_hold = s_q.trip_dur;
			if (!s_q.trip_out) s_d.trip_cnt = s_q.trip_cnt + 16'h0001;
		end else if (s_q.trip_out && pcyc_tick) begin
			if (s_q.trip_cnt_hold == 6'h00) s_d.trip_out = 1'b0;
			else s_d.trip_cnt_hold = s_q.trip_cnt_hold - 6'h01;
		end
		if (s_q.trip_out) s_d.open_out = 1'b0;
		// Close output; zero failure time ends only on breaker closed or trip
		if (s_q.close_out) begin
			if (s_q.brk_s2[0] || s_q.trip_out) s_d.close_out = 1'b0;
			else if (s_q.close_fail != 14'h0000 && pcyc_tick) begin
				if (s_q.close_cnt <= 14'h0001) s_d.close_out = 1'b0;
				else s_d.close_cnt = s_q.close_cnt - 14'h0001;
			end
		end
		// Automatic message routing by port code, skipping timed-out ports
		s_d.msg_ports[1:0] = auto_msg_req ? (s_q.auto_sel & ~s_q.tmo_s2) : 2'h0;
		s_d.msg_ports[2]   = s_q.trigger;
		// Read data, valid the cycle after the strobe
		s_d.rdata = 32'h00000000;
		if (rd_en) begin
			unique case (addr)
				`REG_CMD:      s_d.rdata = {27'h0000000, s_q.cmd};
				`REG_ARG:      s_d.rdata = {16'h0000, s_q.arg};
				`REG_STATUS:   s_d.rdata = {24'h000000, s_q.st, s_q.ses.reject, s_q.ses.fails, s_q.ses.level};
				`REG_GROUP:    s_d.rdata = {29'h00000000, s_q.group};
				`REG_CLOSE_FAIL: s_d.rdata = {18'h00000, s_q.close_fail};
				`REG_TRIP_DUR: s_d.rdata = {26'h0000000, s_q.trip_dur};
				`REG_AUTO:     s_d.rdata = {30'h00000000, s_q.auto_sel};
				`REG_TRIPCNT:  s_d.rdata = {16'h0000, s_q.trip_cnt};
				`REG_EXTCNT:   s_d.rdata = {16'h0000, s_q.xtrig_cnt};
				`REG_EVENT:    s_d.rdata = {28'h0000000, s_q.event_idx};
				`REG_TARGET:   s_d.rdata = {28'h0000000, s_q.target_sel};
				`REG_STAMP:    s_d.rdata = s_q.stamp;
				`REG_YEAR:     s_d.rdata = {20'h00000, s_q.year};
				`REG_INASSIGN: s_d.rdata = {27'h0000000, s_q.dem_on_grp, 1'b0, s_q.in_assign};
				`REG_SETPTR:   s_d.rdata = {28'h0000000, s_q.set_ptr};
				default:       s_d.rdata = 32'h00000000;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			s_q            <= '0;
			s_q.st         <= relay_cmd_pkg::ST_IDLE;
			s_q.group      <= 3'h1;
			s_q.close_fail <= `CLOSE_FAIL_RESET;
			s_q.trip_dur   <= `TRIP_DUR_RESET;
			s_q.auto_sel   <= `AUTO_RESET;
			s_q.event_idx  <= 4'h1;
			s_q.dem_on_grp <= 1'b1;
			s_q.in_assign  <= 3'h1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata               = s_q.rdata;
	assign alarm_out           = s_q.alarm;
	assign clear_events        = s_q.clr_events;
	assign demand_reset        = s_q.dem_reset;
	assign event_trigger       = s_q.trigger;
	assign close_out           = s_q.close_out;
	assign open_out            = s_q.open_out;
	assign trip_out            = s_q.trip_out;
	assign auto_msg_port       = s_q.msg_ports[1:0];
	assign external_event_type = s_q.msg_ports[2];
	assign time_override       = s_q.time_ovr;

	// Third failed level-one attempt starts the alarm next cycle
	a_login_fail_alarm: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h01 && !login_ok && s_q.ses.fails == 2'h2)
		|=> alarm_out && s_q.alarm_cnt == alarm_len) else $error("alarm missing on third failure");
	a_quit_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h09 && s_q.ses.level != 2'h0)
		|=> s_q.ses.level == 2'h0 && s_q.target_sel == 4'h0) else $error("quit failed");
	a_reject_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h0d && s_q.ses.level != 2'h2)
		|=> $stable(s_q.group) && s_q.ses.reject) else $error("group changed without level");
	a_close_jumper: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(close_out) |-> $past(breaker_jumper)) else $error("close without jumper");
	a_target_range: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_q.target_sel <= `TARGET_MAX) else $error("target selector out of range");
	a_event_range: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_q.event_idx >= 4'h1 && s_q.event_idx <= `EVENT_MAX) else $error("event index out of range");
	sequence store_cmd;
		s_q.st == relay_cmd_pkg::ST_GLOBS && wr_en && addr == `REG_CMD && wdata[4:0] == 5'h10;
	endsequence
	a_global_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
		store_cmd |=> clear_events && alarm_out ##1 !clear_events) else $error("global store effects");
	a_auto_ports: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(auto_msg_port & s_q.tmo_s2 & $past(s_q.tmo_s2)) == 2'h0 || !$stable(s_q.tmo_s2))
		else $error("message to timed-out port");
	a_counter_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h03 && s_q.ses.level != 2'h0)
		|=> s_q.isum == 32'h00000000 && s_q.stamp == $past(time_now)) else $error("counter reset");
	// Per-command effects, seen the cycle after the exec cycle; external event type one cycle later
	a_level2_alarm: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h02 && s_q.ses.level != 2'h0)
		|=> alarm_out && s_q.alarm_cnt == alarm_len) else $error("level two login without alarm");
	a_counter_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h03 && s_q.ses.level != 2'h0 && !s_q.brk_s2[1])
		|=> s_q.trip_cnt == 16'h0000 && s_q.xtrig_cnt == 16'h0000) else $error("trip counters not cleared");
	a_date_alarm: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h04 && s_q.ses.level != 2'h0 && s_q.arg[11:0] != s_q.year)
		|=> alarm_out && s_q.year == $past(s_q.arg[11:0])) else $error("year change without alarm");
	a_target_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h07 && s_q.ses.level != 2'h0)
		|=> s_q.target_sel == 4'h0) else $error("target reset left selector");
	a_trigger_type: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h08 && s_q.ses.level != 2'h0)
		|=> event_trigger ##1 external_event_type) else $error("trigger not marked external");
	a_copy_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h0c && s_q.ses.level == 2'h2)
		|=> clear_events || s_q.ses.reject) else $error("copy kept event buffers");
	a_group_held: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h0d && s_q.ses.level == 2'h2 &&
		((s_q.in_assign[0] & s_q.sel_s2[0]) | (s_q.in_assign[1] & s_q.sel_s2[1])))
		|=> $stable(s_q.group) && s_q.ses.reject) else $error("group changed with select input high");
	a_store_group: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h0e && s_q.ses.level == 2'h2)
		|=> clear_events) else $error("group store kept event buffers");
	a_glob_entry: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(s_q.st == relay_cmd_pkg::ST_EXEC && s_q.cmd == 5'h0f && s_q.ses.level == 2'h2)
		|=> s_q.st == relay_cmd_pkg::ST_GLOBS && s_q.set_ptr == $past(s_q.arg[3:0])) else $error("global entry");
	// Side effects that follow state rather than a command
	a_demand_group: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_q.group != $past(s_q.group) |-> demand_reset == $past(s_q.dem_on_grp)) else $error("demand reset");
	a_close_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		close_out && s_q.close_fail == 14'h0000 && (s_q.brk_s2[0] || trip_out)
		|=> !close_out) else $error("close held after breaker closed");
	a_open_jumper: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(open_out) |-> $past(breaker_jumper)) else $error("open without jumper");
	a_auto_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
		s_q.auto_sel != 2'h0) else $error("automatic port code zero");
	a_trip_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
		trip_out && !s_q.brk_s2[1] && !pcyc_tick |=> trip_out) else $error("trip dropped between ticks");
endmodule // relay_cmd
`default_nettype wire

/* File: dv/breaker_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Breaker mechanism seen by the relay: closes a while after the close coil, opens on trip or open
module breaker_model #(
	parameter int CLOSE_LAG = 6
) (
	input  wire logic clk_sys,
	input  wire logic close_out,
	input  wire logic open_out,
	input  wire logic trip_out,
	output var logic  breaker_status_input
);
	int lag = 0;
	initial breaker_status_input = 1'b0;
	// Mechanism lags the coil, so a relay that drops close too soon never sees it closed
	always @(posedge clk_sys) begin
		lag <= close_out ? lag + 1 : 0;
		if (trip_out || open_out)
			breaker_status_input <= 1'b0;
		else if (lag == CLOSE_LAG)
			breaker_status_input <= 1'b1;
	end
endmodule // breaker_model
`default_nettype wire

/* File: dv/test_relay_command_and_global_setting.sv */
`timescale 1ns/1ps
`default_nettype none
`include "relay_cmd_regs.svh"
module test_relay_command_and_global_setting;
	localparam int ALARM_N = 20;
	localparam int PCYC    = 10;
	logic        clk_sys, reset_n, wr_en, rd_en, login_ok, breaker_jumper, trip_request;
	logic        time_code_valid, auto_msg_req, breaker_status_input;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  port_timed_out, auto_msg_port;
	logic        alarm_out, clear_events, demand_reset, event_trigger, close_out, open_out, trip_out;
	logic        external_event_type, time_override, trig_q, alarm_q, sel_one;
	logic [15:0] rnd;
	logic [2:0]  g, other;
	int          err_count, check_count, alarm_n, alarm_hi, clr_n, dem_n, trig_n, xtype_n, n, a0, c0, d0;

	relay_cmd #(.ALARM_CYCLES(ALARM_N), .PCYC_CLKS(PCYC)) DUT (
		.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata), .login_ok(login_ok), .group_sel_one(sel_one), .group_sel_two(1'b0),
		.breaker_status_input(breaker_status_input), .breaker_jumper(breaker_jumper),
		.trip_request(trip_request), .port_timed_out(port_timed_out), .time_code_valid(time_code_valid),
		.time_now(32'h1234_5678), .auto_msg_req(auto_msg_req), .alarm_out(alarm_out),
		.clear_events(clear_events), .demand_reset(demand_reset), .event_trigger(event_trigger),
		.close_out(close_out), .open_out(open_out), .trip_out(trip_out), .auto_msg_port(auto_msg_port),
		.external_event_type(external_event_type), .time_override(time_override));
	breaker_model #(.CLOSE_LAG(6)) far_side (.clk_sys(clk_sys), .close_out(close_out), .open_out(open_out),
		.trip_out(trip_out), .breaker_status_input(breaker_status_input));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Pulse counters, so scenarios compare counts or deltas rather than exact edges
	always @(posedge clk_sys) begin
		alarm_q <= alarm_out;
		trig_q <= event_trigger;
		if (alarm_out === 1'b1 && alarm_q !== 1'b1) alarm_n++;
		if (alarm_out === 1'b1) alarm_hi++;
		if (clear_events === 1'b1) clr_n++;
		if (demand_reset === 1'b1) dem_n++;
		if (event_trigger === 1'b1) trig_n++;
		if (trig_q === 1'b1 && external_event_type === 1'b1) xtype_n++;
	end

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			err_count++;
		end
	endtask

	task automatic bound_out(input int cnt, input int lim);
		if (cnt >= lim) begin
			err_count++;
			tally_and_finish();
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rchk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
		@(posedge clk_sys);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		#1 chk(rdata & mask, exp);
	endtask

	// Argument first, then the code; long idle lets any alarm pulse finish
	task automatic cmd(input logic [4:0] c, input logic [15:0] a);
		wr(`REG_ARG, {16'h0000, a});
		wr(`REG_CMD, {27'h0, c});
		repeat (ALARM_N + 10) @(posedge clk_sys);
	endtask

	task automatic step(input logic [4:0] c, input logic [15:0] a, input int da, input int dc, input int dd);
		a0 = alarm_n;
		c0 = clr_n;
		d0 = dem_n;
		cmd(c, a);
		chk(alarm_n - a0, da);
		chk(clr_n - c0, dc);
		chk(dem_n - d0, dd);
	endtask

	initial begin
		repeat (60000) @(posedge clk_sys);
		err_count++;
		tally_and_finish();
	end

	initial begin
		{reset_n, wr_en, rd_en, login_ok, breaker_jumper, trip_request, time_code_valid, auto_msg_req, sel_one} = '0;
		{addr, wdata, port_timed_out} = '0;
		rnd = 16'h3696;
		repeat (10) @(posedge clk_sys);
		reset_n <= 1'b1;
		rchk(`REG_CLOSE_FAIL, 32'h3fff, 32'h3c);
		rchk(`REG_TRIP_DUR, 32'h3f, 32'h4);
		rchk(`REG_AUTO, 32'h3, 32'h3);
		step(relay_cmd_pkg::CMD_GROUP, 16'h3, 0, 0, 0);
		rchk(`REG_GROUP, 32'h7, 32'h1);
		step(relay_cmd_pkg::CMD_TRIGGER, 16'h0, 0, 0, 0);
		chk(trig_n, 0);
		$display("test refusal done");
		// Password lockout: only the third miss raises the alarm
		step(relay_cmd_pkg::CMD_LOGIN1, 16'h0, 0, 0, 0);
		step(relay_cmd_pkg::CMD_LOGIN1, 16'h0, 0, 0, 0);
		d = alarm_hi;
		step(relay_cmd_pkg::CMD_LOGIN1, 16'h0, 1, 0, 0);
		chk(alarm_hi - d, ALARM_N);
		login_ok <= 1'b1;
		step(relay_cmd_pkg::CMD_LOGIN1, 16'h0, 0, 0, 0);
		login_ok <= 1'b0;
		step(relay_cmd_pkg::CMD_LOGIN2, 16'h0, 1, 0, 0);
		rchk(`REG_STATUS, 32'h3, 32'h1);
		login_ok <= 1'b1;
		step(relay_cmd_pkg::CMD_LOGIN2, 16'h0, 1, 0, 0);
		rchk(`REG_STATUS, 32'h3, 32'h2);
		$display("test login done");
		for (int t = 0; t <= 8; t++) begin
			cmd(relay_cmd_pkg::CMD_TARGET, 16'(t));
			rchk(`REG_TARGET, 32'hf, 32'(t));
		end
		cmd(relay_cmd_pkg::CMD_TAR_RST, 16'h0);
		rchk(`REG_TARGET, 32'hf, 32'h0);
		// Both ends of the record index, then random ones
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr_next(rnd);
			n = (i == 0) ? 1 : (i == 1) ? 12 : 32'(rnd % 12) + 1;
			cmd(relay_cmd_pkg::CMD_EVENT, 16'(n));
			rchk(`REG_EVENT, 32'hf, 32'(n));
		end
		cmd(relay_cmd_pkg::CMD_TRIGGER, 16'h0);
		chk(trig_n, 1);
		chk(xtype_n, 1);
		$display("test display done");
		rnd = lfsr_next(rnd);
		g = 3'(rnd % 5) + 3'h2;
		other = (g == 3'h6) ? 3'h2 : g + 3'h1;
		step(relay_cmd_pkg::CMD_GROUP, {13'h0, g}, 1, 0, 1);
		rchk(`REG_GROUP, 32'h7, {29'h0, g});
		step(relay_cmd_pkg::CMD_GROUP, {13'h0, g}, 0, 0, 0);
		// Asserted select input locks the active group
		sel_one <= 1'b1;
		repeat (4) @(posedge clk_sys);
		step(relay_cmd_pkg::CMD_GROUP, {13'h0, other}, 0, 0, 0);
		rchk(`REG_GROUP, 32'h7, {29'h0, g});
		sel_one <= 1'b0;
		step(relay_cmd_pkg::CMD_COPY, {9'h0, g, 4'h1}, 1, 1, 0);
		step(relay_cmd_pkg::CMD_COPY, {9'h0, other, 4'h1}, 0, 1, 0);
		step(relay_cmd_pkg::CMD_SET_GRP, {13'h0, g}, 1, 1, 0);
		step(relay_cmd_pkg::CMD_SET_GRP, {13'h0, other}, 0, 1, 0);
		step(relay_cmd_pkg::CMD_SET_GLB, 16'h2, 0, 0, 0);
		rchk(`REG_SETPTR, 32'hf, 32'h2);
		step(relay_cmd_pkg::CMD_SET_GLB, 16'h0, 0, 0, 0);
		rchk(`REG_SETPTR, 32'hf, 32'h0);
		step(relay_cmd_pkg::CMD_STORE_G, 16'h0, 1, 1, 0);
		cmd(relay_cmd_pkg::CMD_DATE, 16'h7d0);
		step(relay_cmd_pkg::CMD_DATE, 16'h7d0, 0, 0, 0);
		step(relay_cmd_pkg::CMD_DATE, 16'h7d1, 1, 0, 0);
		time_code_valid <= 1'b1;
		@(posedge clk_sys);
		#1 chk(time_override, 1);
		$display("test settings done");
		wr(`REG_CLOSE_FAIL, 32'h0);
		wr(`REG_CLOSE_FAIL, 32'h3e81);
		rchk(`REG_CLOSE_FAIL, 32'h3fff, 32'h0);
		wr(`REG_TRIP_DUR, 32'h3);
		cmd(relay_cmd_pkg::CMD_CLOSE, 16'h0);
		chk(close_out, 0);
		breaker_jumper <= 1'b1;
		cmd(relay_cmd_pkg::CMD_CLOSE, 16'h0);
		// Close must fall only once the breaker reports closed
		for (n = 0; n < 50 && close_out !== 1'b0; n++) @(posedge clk_sys);
		bound_out(n, 50);
		chk(breaker_status_input, 1);
		trip_request <= 1'b1;
		repeat (3) @(posedge clk_sys);
		trip_request <= 1'b0;
		for (n = 0; n < 20 && trip_out !== 1'b1; n++) @(posedge clk_sys);
		bound_out(n, 20);
		for (n = 0; n < 200 && trip_out === 1'b1; n++) @(posedge clk_sys);
		chk(n >= 3 * PCYC && n <= 4 * PCYC + 4, 1);
		cmd(relay_cmd_pkg::CMD_BRK_RST, 16'h0);
		rchk(`REG_TRIPCNT, 32'hffff, 32'h0);
		rchk(`REG_EXTCNT, 32'hffff, 32'h0);
		rchk(`REG_STAMP, 32'hffff_ffff, 32'h1234_5678);
		$display("test breaker done");
		// Each port code 1 to 3, first with no port timed out, then random timed-out ports
		for (int s = 1; s <= 3; s++) begin
			wr(`REG_AUTO, 32'(s));
			for (int t = 0; t < 3; t++) begin
				rnd = lfsr_next(rnd);
				port_timed_out <= (t == 0) ? 2'h0 : rnd[1:0];
				repeat (4) @(posedge clk_sys);
				auto_msg_req <= 1'b1;
				@(posedge clk_sys);
				auto_msg_req <= 1'b0;
				#1 chk(auto_msg_port, 2'(s) & ~port_timed_out);
			end
		end
		wr(`REG_AUTO, 32'h0);
		rchk(`REG_AUTO, 32'h3, 32'h3);
		cmd(relay_cmd_pkg::CMD_TARGET, 16'h5);
		cmd(relay_cmd_pkg::CMD_QUIT, 16'h0);
		rchk(`REG_STATUS, 32'h3, 32'h0);
		rchk(`REG_TARGET, 32'hf, 32'h0);
		$display("test ports and quit done");
		tally_and_finish();
	end
endmodule // test_relay_command_and_global_setting
`default_nettype wire
